// ### rtl/adcr_top.sv
/*
  Result and input-select block of a 10-bit converter, AXI4-Lite registers.
  Assumes the converter front end runs on aclk and gives a busy level,
  a one-cycle done pulse and an offset-binary code for differential pairs.
*/
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
// Function
// [R1] Result readable once done flag raised
// [R2] Single-ended result is unsigned 10-bit code
// [R3] Differential result is two's complement
// [R4] Bit 9 is sign for differential results
// [R5] Select register layout, all bits reset zero
// [R6] Decode two-bit reference select
// [R7] Reference change waits for conversion end
// [R8] Internal reference powers on when needed
// [R9] Left-adjust bit left-justifies result
// [R10] Left-adjust change alters result bytes immediately
// [R11] Byte placement for left and right justification
// [R12] Low byte read locks updates until high
// [R13] Decode four-bit channel select
// [R14] Done flag only after result update
// [R15] Unused select bit reads zero, ignores writes
`timescale 1ns/100ps
module adcr_top (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   // AXI4-Lite read
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   // Converter front end
   input wire logic conv_busy,
   input wire logic conv_done,
   input wire logic [9:0] conv_code,
   // Analog steering and result sign
   output logic [1:0] ref_select,
   output logic [3:0] chan_select,
   output logic chan_diff,
   output logic ref_pin_on,
   output logic analog_supply_on,
   output logic internal_ref_on,
   output logic result_sign_bit,
   // Interrupt
   output logic irq
);
   import adcr_pkg::*;
   `include "adcr_consts.svh"

   adcr_reg_if rif ();
   adcr_top_s s_reg;
   adcr_top_s s_next;
   logic [7:0] res_lo;
   logic [7:0] res_hi;
   logic [7:0] wbyte;
   adcr_reg_e rd_idx;
   adcr_reg_e wr_idx;

   // ----------------------------------------
   // Decoding helpers
   // ----------------------------------------
   // Low two address bits are ignored; each register is one aligned word
   function automatic adcr_reg_e reg_decode(input logic [7:0] addr);
      case ({addr[7:2], 2'h0})
         `ADCR_OFF_SEL: reg_decode = REG_SEL;
         `ADCR_OFF_RLO: reg_decode = REG_RLO;
         `ADCR_OFF_RHI: reg_decode = REG_RHI;
         `ADCR_OFF_STAT: reg_decode = REG_STAT;
         `ADCR_OFF_ISTAT: reg_decode = REG_ISTAT;
         `ADCR_OFF_IMASK: reg_decode = REG_IMASK;
         `ADCR_OFF_CTRL: reg_decode = REG_CTRL;
         default: reg_decode = REG_NONE;
      endcase
   endfunction : reg_decode

   // Amplifier outputs are the differential channels; all others single
   function automatic logic chan_is_diff(input logic [3:0] ch);
      chan_is_diff = (ch == `ADCR_CH_AMP0) || (ch == `ADCR_CH_AMP1); // [R13]
   endfunction : chan_is_diff

   // One-hot source enables {internal, supply, pin}; reserved drives none
   function automatic logic [2:0] ref_decode(input logic [1:0] rs, input logic aen);
      case (rs)
         `ADCR_REF_PIN: ref_decode = 3'h1; // [R6]
         `ADCR_REF_SUPPLY: ref_decode = 3'h2;
         `ADCR_REF_INT: ref_decode = {aen, 2'h0}; // [R8]
         default: ref_decode = 3'h0;
      endcase
   endfunction : ref_decode

   // ----------------------------------------
   // Bus slave and formatter
   // ----------------------------------------
   adcr_axil_slave u_slave (
      .aclk(aclk),
      .aresetn(aresetn),
      .awvalid(s_axi_awvalid),
      .awready(s_axi_awready),
      .awaddr(s_axi_awaddr),
      .wvalid(s_axi_wvalid),
      .wready(s_axi_wready),
      .wdata(s_axi_wdata),
      .wstrb(s_axi_wstrb),
      .bvalid(s_axi_bvalid),
      .bready(s_axi_bready),
      .bresp(s_axi_bresp),
      .arvalid(s_axi_arvalid),
      .arready(s_axi_arready),
      .araddr(s_axi_araddr),
      .rvalid(s_axi_rvalid),
      .rready(s_axi_rready),
      .rdata(s_axi_rdata),
      .rresp(s_axi_rresp),
      .rif(rif.slv)
   );

   // Justification follows the live select bit, not the stored one
   adcr_result_fmt u_fmt (
      .raw(s_reg.raw),
      .diff(s_reg.raw_diff),
      .left(s_reg.sel[`ADCR_SEL_LEFT]), // [R10]
      .code(),
      .res_lo(res_lo),
      .res_hi(res_hi)
   );

   // ----------------------------------------
   // Register read and decode answers
   // ----------------------------------------
   always_comb begin
      rd_idx = reg_decode(rif.rd_addr);
      wr_idx = reg_decode(rif.wr_addr);
      rif.rd_err = (rd_idx == REG_NONE);
      rif.wr_err = (wr_idx == REG_NONE);
      case (rd_idx)
         REG_SEL: rif.rd_data = {24'h000000, s_reg.sel};
         REG_RLO: rif.rd_data = {24'h000000, res_lo}; // [R1]
         REG_RHI: rif.rd_data = {24'h000000, res_hi}; // [R1]
         REG_STAT: rif.rd_data = {29'h00000000, conv_busy, s_reg.lock, s_reg.done};
         REG_ISTAT: rif.rd_data = {30'h00000000, s_reg.istat};
         REG_IMASK: rif.rd_data = {30'h00000000, s_reg.imask};
         REG_CTRL: rif.rd_data = {31'h00000000, s_reg.aen};
         default: rif.rd_data = 32'h00000000;
      endcase
   end

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_next = s_reg;
      wbyte = rif.wr_data[7:0];
      // Software writes; only byte lane 0 carries the 8-bit registers
      if (rif.wr_en && rif.wr_strb[0]) begin
         case (wr_idx)
            REG_SEL: s_next.sel = wbyte & `ADCR_SEL_WMASK; // [R5] [R15]
            REG_STAT: begin
               if (wbyte[0]) begin
                  s_next.done = 1'b0;
               end
            end
            REG_IMASK: s_next.imask = wbyte[1:0];
            REG_CTRL: s_next.aen = wbyte[0];
            default: begin
               s_next.aen = s_reg.aen;
            end
         endcase
      end
      // Read side effects: the lock pair and clear-on-read status
      if (rif.rd_en) begin
         case (rd_idx)
            REG_RLO: s_next.lock = 1'b1; // [R12]
            REG_RHI: s_next.lock = 1'b0; // [R12]
            REG_ISTAT: s_next.istat = 2'h0;
            default: begin
               s_next.lock = s_reg.lock;
            end
         endcase
      end
      // Conversion end; placed after clears so a new event wins
      if (conv_done) begin
         if (!s_reg.lock) begin
            s_next.raw = conv_code; // [R14]
            s_next.raw_diff = chan_is_diff(s_reg.app_ch); // [R3]
            s_next.done = 1'b1; // [R14] [R1]
            s_next.istat[`ADCR_IRQ_DONE] = 1'b1;
         end else begin
            // Result dropped while a split read is open
            s_next.istat[`ADCR_IRQ_DROP] = 1'b1; // [R12]
         end
      end
      // Applied selection follows the register only outside a conversion
      if (!conv_busy || conv_done) begin
         s_next.app_ref = s_next.sel[`ADCR_SEL_REF_HI:`ADCR_SEL_REF_LO]; // [R7]
         s_next.app_ch = s_next.sel[`ADCR_SEL_CH_HI:0]; // [R7] [R13]
      end
      // Registered outputs
      s_next.ref_on = ref_decode(s_next.app_ref, s_next.aen); // [R6] [R8]
      s_next.chan_diff = chan_is_diff(s_next.app_ch); // [R13]
      s_next.sign = s_next.raw_diff ? ~s_next.raw[9] : s_next.raw[9]; // [R4]
      s_next.irq = |(s_next.istat & s_next.imask);
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg <= '0; // [R5]
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign ref_select = s_reg.app_ref;
   assign chan_select = s_reg.app_ch;
   assign chan_diff = s_reg.chan_diff;
   assign ref_pin_on = s_reg.ref_on[0];
   assign analog_supply_on = s_reg.ref_on[1];
   assign internal_ref_on = s_reg.ref_on[2];
   assign result_sign_bit = s_reg.sign;
   assign irq = s_reg.irq;
endmodule : adcr_top

// ### rtl/adcr_consts.svh
/*
  Offsets, field positions, reset values and codes of the result and
  input-select block. Assumes an 8-bit byte address on the register bus.
*/
`ifndef ADCR_CONSTS_SVH
`define ADCR_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ADCR_OFF_SEL 8'h00
`define ADCR_OFF_RLO 8'h04
`define ADCR_OFF_RHI 8'h08
`define ADCR_OFF_STAT 8'h0C
`define ADCR_OFF_ISTAT 8'h10
`define ADCR_OFF_IMASK 8'h14
`define ADCR_OFF_CTRL 8'h18

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define ADCR_SEL_RESET 8'h00
`define ADCR_SEL_WMASK 8'hEF
`define ADCR_SEL_LEFT 5
`define ADCR_SEL_REF_HI 7
`define ADCR_SEL_REF_LO 6
`define ADCR_SEL_CH_HI 3
`define ADCR_IRQ_BITS 2
`define ADCR_IRQ_DONE 0
`define ADCR_IRQ_DROP 1

// ----------------------------------------
// Reference and channel codes
// ----------------------------------------
`define ADCR_REF_PIN 2'h0
`define ADCR_REF_SUPPLY 2'h1
`define ADCR_REF_RSVD 2'h2
`define ADCR_REF_INT 2'h3
`define ADCR_CH_AMP0 4'hB
`define ADCR_CH_AMP1 4'hC

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define ADCR_RESP_OKAY 2'h0
`define ADCR_RESP_SLVERR 2'h2

`endif

// ### rtl/adcr_pkg.sv
/*
  Types of the result and input-select block: register index, bus states
  and the packed state records of the bus slave and the top module. Assumes adcr_consts.svh.
*/
package adcr_pkg;

   // ----------------------------------------
   // Register index and bus states
   // ----------------------------------------
   typedef enum logic [2:0] {
      REG_SEL, REG_RLO, REG_RHI, REG_STAT, REG_ISTAT, REG_IMASK, REG_CTRL, REG_NONE
   } adcr_reg_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0, ST_RD = 2'h1, ST_RRESP = 2'h3, ST_WRESP = 2'h2
   } adcr_axst_e;

   // ----------------------------------------
   // Module state records
   // ----------------------------------------
   typedef struct packed {
      adcr_axst_e st;
      logic aw_got;
      logic w_got;
      logic [7:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic [7:0] raddr;
      logic awready;
      logic wready;
      logic arready;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } adcr_slv_s;

   typedef struct packed {
      logic [7:0] sel;
      logic [1:0] app_ref;
      logic [3:0] app_ch;
      logic [9:0] raw;
      logic raw_diff;
      logic done;
      logic lock;
      logic [1:0] istat;
      logic [1:0] imask;
      logic aen;
      logic irq;
      logic [2:0] ref_on;
      logic chan_diff;
      logic sign;
   } adcr_top_s;

endpackage : adcr_pkg

// ### rtl/adcr_reg_if.sv
/*
  Register access strobes between the bus slave and the register file.
  Assumes both ends run on the same clock; answers are combinational.
*/
`timescale 1ns/100ps
interface adcr_reg_if;
   logic wr_en;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_err;
   logic rd_en;
   logic [7:0] rd_addr;
   logic [31:0] rd_data;
   logic rd_err;

   // Bus side issues strobes, register side answers
   modport slv (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
      input wr_err, rd_data, rd_err);
   modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
      output wr_err, rd_data, rd_err);
endinterface : adcr_reg_if

// ### rtl/adcr_result_fmt.sv
/*
  Result formatter: number format and justification of the stored code.
  Assumes the raw code is offset binary for differential conversions.
*/
`timescale 1ns/100ps
module adcr_result_fmt (
   // Stored conversion
   input wire logic [9:0] raw,
   input wire logic diff,
   input wire logic left,
   // Formatted bytes
   output logic [9:0] code,
   output logic [7:0] res_lo,
   output logic [7:0] res_hi
);
   // ----------------------------------------
   // Format and justify
   // ----------------------------------------
   // Flipping the top bit turns offset binary into two's complement
   always_comb begin
      code = diff ? {~raw[9], raw[8:0]} : raw; // [R2] [R3] [R4]
      if (left) begin
         res_hi = code[9:2]; // [R9] [R11]
         res_lo = {code[1:0], 6'h00};
      end else begin
         res_hi = {6'h00, code[9:8]}; // [R11]
         res_lo = code[7:0];
      end
   end
endmodule : adcr_result_fmt

// ### rtl/adcr_axil_slave.sv
/*
  AXI4-Lite slave: one write and one read in flight; a write held whole before the read address goes first.
  Assumes the register side answers strobes within the same cycle.
*/
`timescale 1ns/100ps
module adcr_axil_slave (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Write address and data
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // Write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // Read address and data
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Register strobes
   adcr_reg_if.slv rif
);
   import adcr_pkg::*;
   `include "adcr_consts.svh"

   adcr_slv_s s_reg;
   adcr_slv_s s_next;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_next = s_reg;
      case (s_reg.st)
         ST_IDLE: begin
            if (awvalid && s_reg.awready) begin
               s_next.aw_got = 1'b1;
               s_next.waddr = awaddr;
            end
            if (wvalid && s_reg.wready) begin
               s_next.w_got = 1'b1;
               s_next.wdata = wdata;
               s_next.wstrb = wstrb;
            end
            // arready is low here whenever a full write waits
            if (s_reg.aw_got && s_reg.w_got) begin
               s_next.aw_got = 1'b0;
               s_next.w_got = 1'b0;
               s_next.bvalid = 1'b1;
               s_next.bresp = rif.wr_err ? `ADCR_RESP_SLVERR : `ADCR_RESP_OKAY;
               s_next.st = ST_WRESP;
            end else if (arvalid && s_reg.arready) begin
               s_next.raddr = araddr;
               s_next.st = ST_RD;
            end
         end
         ST_RD: begin
            s_next.rvalid = 1'b1;
            s_next.rdata = rif.rd_data;
            s_next.rresp = rif.rd_err ? `ADCR_RESP_SLVERR : `ADCR_RESP_OKAY;
            s_next.st = ST_RRESP;
         end
         ST_RRESP: begin
            if (rready) begin
               s_next.rvalid = 1'b0;
               s_next.st = ST_IDLE;
            end
         end
         ST_WRESP: begin
            if (bready) begin
               s_next.bvalid = 1'b0;
               s_next.st = ST_IDLE;
            end
         end
         default: begin
            s_next = '0;
         end
      endcase
      // Readies derive from the next state so they drop right after a take
      s_next.awready = (s_next.st == ST_IDLE) && !s_next.aw_got;
      s_next.wready = (s_next.st == ST_IDLE) && !s_next.w_got;
      s_next.arready = (s_next.st == ST_IDLE) && !(s_next.aw_got && s_next.w_got);
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign awready = s_reg.awready;
   assign wready = s_reg.wready;
   assign arready = s_reg.arready;
   assign bvalid = s_reg.bvalid;
   assign bresp = s_reg.bresp;
   assign rvalid = s_reg.rvalid;
   assign rdata = s_reg.rdata;
   assign rresp = s_reg.rresp;
   assign rif.wr_en = (s_reg.st == ST_IDLE) && s_reg.aw_got && s_reg.w_got;
   assign rif.wr_addr = s_reg.waddr;
   assign rif.wr_data = s_reg.wdata;
   assign rif.wr_strb = s_reg.wstrb;
   assign rif.rd_en = (s_reg.st == ST_RD);
   assign rif.rd_addr = s_reg.raddr;
endmodule : adcr_axil_slave

// ### test/adcr_top_chk.sv
/*
  Port-level checker of the result and input-select block, bound to adcr_top.
  Assumes one clock, aclk, and the synchronous active-low reset aresetn.
*/
`timescale 1ns/100ps
module adcr_top_chk (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Converter and steering
   input wire logic conv_busy,
   input wire logic conv_done,
   input wire logic [1:0] ref_select,
   input wire logic [3:0] chan_select,
   input wire logic chan_diff,
   input wire logic ref_pin_on,
   input wire logic analog_supply_on,
   input wire logic internal_ref_on
);
   // ----------------------------------------
   // Steering outputs
   // ----------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Three stable samples leave room for one register stage of lag
   a_ref_pin_decode: assert property ((ref_select == 2'h0)[*3] |-> ref_pin_on)
      else $error("reference pin not enabled for select 00");
   a_supply_decode: assert property ((ref_select == 2'h1)[*3] |-> analog_supply_on)
      else $error("analog supply not enabled for select 01");
   a_int_ref_off: assert property ((ref_select != 2'h3)[*3] |-> !internal_ref_on)
      else $error("internal reference on without select 11");
   a_chan_diff_map: assert property ($stable(chan_select)[*3] |->
      chan_diff == (chan_select inside {4'hB, 4'hC}))
      else $error("differential flag disagrees with channel");
   // Applied selection must not move inside a running conversion
   a_sel_frozen: assert property (conv_busy && !conv_done |=>
      $stable(ref_select) && $stable(chan_select))
      else $error("applied selection moved during conversion");

   // ----------------------------------------
   // Register bus
   // ----------------------------------------
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before handshake");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before handshake");
   a_read_latency: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
      else $error("read answer not two edges after address");
   a_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer not two edges after address");
   a_resp_refuse: assert property (s_axi_bvalid |->
      !s_axi_awready && !s_axi_wready && !s_axi_arready)
      else $error("ready high while a write response is out");

   // Main scenarios reached
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_conv: cover property (conv_busy && !conv_done ##1 conv_done);
endmodule : adcr_top_chk

bind adcr_top adcr_top_chk i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
   .conv_busy, .conv_done, .ref_select, .chan_select, .chan_diff, .ref_pin_on,
   .analog_supply_on, .internal_ref_on);

// ### test/adc_result_and_input_select_tb.sv
/*
  Self-checking bench of adcr_top: register accesses over AXI4-Lite and a
  behavioural converter front end. Assumes the register map of the note.
*/
`timescale 1ns/100ps
`include "adcr_consts.svh"
module adc_result_and_input_select_tb;
   import adcr_pkg::*;
   // ----------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic conv_busy = 1'b0, conv_done = 1'b0;
   logic [9:0] conv_code = 10'h000;
   logic awready, wready, bvalid, arready, rvalid, chan_diff, irq, result_sign_bit;
   logic ref_pin_on, analog_supply_on, internal_ref_on;
   logic [1:0] bresp, rresp, ref_select, rsp;
   logic [3:0] chan_select;
   logic [31:0] rdata, val;
   int errors = 0;
   int cmp_count = 0;

   adcr_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .conv_busy(conv_busy), .conv_done(conv_done),
      .conv_code(conv_code), .ref_select(ref_select), .chan_select(chan_select),
      .chan_diff(chan_diff), .ref_pin_on(ref_pin_on), .analog_supply_on(analog_supply_on),
      .internal_ref_on(internal_ref_on), .result_sign_bit(result_sign_bit), .irq(irq));

   // 25 MHz clock
   always #20 aclk = ~aclk;

   // ----------------------------------------
   // Bus, converter and comparison tasks
   // ----------------------------------------
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // Address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ta;
      logic tw;
      ta = 1'b0;
      tw = 1'b0;
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      bready <= 1'b1;
      while (!(ta && tw)) begin
         @(posedge aclk);
         if (awvalid && awready && !ta) begin
            ta = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready && !tw) begin
            tw = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      rsp = bresp;
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge aclk);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : rd

   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      chk(n, e, d);
   endtask : rc

   task automatic conv_start;
      @(posedge aclk);
      conv_busy <= 1'b1;
      repeat (3) @(posedge aclk);
   endtask : conv_start

   // Done pulse carries the code; busy falls with it
   task automatic conv_end(input logic [9:0] c);
      conv_done <= 1'b1;
      conv_code <= c;
      @(posedge aclk);
      conv_done <= 1'b0;
      conv_busy <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask : conv_end

   task automatic close_out;
      if (errors == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : close_out

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rc(`ADCR_OFF_SEL, 32'h0, "sel_reset");
      wr(`ADCR_OFF_SEL, 32'hFF);
      chk("bresp_okay", 32'(`ADCR_RESP_OKAY), 32'(rsp));
      rc(`ADCR_OFF_SEL, 32'hEF, "sel_unused_bit");
      // Unmapped write must answer with an error and change nothing
      wr(8'h1C, 32'h0);
      chk("unmapped_bresp", 32'(`ADCR_RESP_SLVERR), 32'(rsp));
      rd(8'h1C, val, rsp);
      chk("unmapped_resp", 32'(`ADCR_RESP_SLVERR), 32'(rsp));
      wr(`ADCR_OFF_CTRL, 32'h1);
      for (int i = 0; i < 4; i++) begin
         wr(`ADCR_OFF_SEL, 32'(i << 6));
         repeat (3) @(posedge aclk);
         chk("ref", 32'(i), 32'(ref_select));
         chk("ref_pins", 32'({i == 3, i == 1, i == 0}),
            32'({internal_ref_on, analog_supply_on, ref_pin_on}));
      end
      wr(`ADCR_OFF_CTRL, 32'h0);
      repeat (3) @(posedge aclk);
      chk("int_ref_idle", 32'h0, 32'(internal_ref_on));
      for (int i = 0; i < 16; i++) begin
         wr(`ADCR_OFF_SEL, 32'(i));
         repeat (3) @(posedge aclk);
         chk("chan", 32'(i), 32'(chan_select));
         chk("chan_diff", 32'(i == 11 || i == 12), 32'(chan_diff));
      end
      // Single-ended full scale, right adjusted, interrupt raised then cleared
      wr(`ADCR_OFF_IMASK, 32'h1);
      wr(`ADCR_OFF_SEL, 32'h0);
      conv_start();
      conv_end(10'h3FF);
      rc(`ADCR_OFF_STAT, 32'h1, "done_flag");
      chk("irq_set", 32'h1, 32'(irq));
      rc(`ADCR_OFF_RLO, 32'hFF, "se_low");
      rc(`ADCR_OFF_RHI, 32'h03, "se_high");
      rc(`ADCR_OFF_ISTAT, 32'h1, "istat");
      repeat (2) @(posedge aclk);
      chk("irq_clear", 32'h0, 32'(irq));
      // Done flag clears on a one written to it
      wr(`ADCR_OFF_STAT, 32'h1);
      rc(`ADCR_OFF_STAT, 32'h0, "done_clear");
      // Differential, left adjusted: minus 400
      wr(`ADCR_OFF_SEL, 32'h2B);
      conv_start();
      conv_end(10'h070);
      rc(`ADCR_OFF_RLO, 32'h00, "diff_left_low");
      rc(`ADCR_OFF_RHI, 32'h9C, "diff_left_high");
      chk("sign_neg", 32'h1, 32'(result_sign_bit));
      // Adjust and reference changed inside a conversion
      conv_start();
      wr(`ADCR_OFF_SEL, 32'h4B);
      rc(`ADCR_OFF_RLO, 32'h70, "right_low_busy");
      rc(`ADCR_OFF_RHI, 32'h02, "right_high_busy");
      chk("ref_held", 32'h0, 32'(ref_select));
      conv_end(10'h229);
      chk("ref_applied", 32'h1, 32'(ref_select));
      chk("sign_pos", 32'h0, 32'(result_sign_bit));
      wr(`ADCR_OFF_SEL, 32'h6B);
      rc(`ADCR_OFF_RLO, 32'h40, "left_low");
      // Low byte read locks out the next result until high byte is read
      conv_start();
      conv_end(10'h3FF);
      rc(`ADCR_OFF_RHI, 32'h0A, "locked_high");
      rc(`ADCR_OFF_ISTAT, 32'h3, "drop_event");
      wr(`ADCR_OFF_IMASK, 32'h0);
      conv_start();
      conv_end(10'h3FF);
      repeat (2) @(posedge aclk);
      chk("irq_masked", 32'h0, 32'(irq));
      rc(`ADCR_OFF_RHI, 32'h7F, "unlocked_high");
      close_out();
   end

   // Watchdog, far beyond the few hundred cycles the sequence needs
   initial begin
      #(40 * 20000);
      errors++;
      close_out();
   end
endmodule : adc_result_and_input_select_tb
